// ==== src/spdc_ctrl.sv ====
/*
 * Top of the single pin debug controller: pin synchroniser, transmitter,
 * error recovery, debug mode control, breakpoint handling and the debug
 * event counter. Assumes command decoding sits outside and uses the
 * byte and register ports; i_arst_n gathers power-on, brown-out and
 * pin reset.
 */
`timescale 1ns/100ps
// Operation
// - In debug mode CPU fetch stops, halt exits, watchdog is refreshed.
// - Enter debug by control write, breakpoint, PC match, countdown end.
// - Pin low when reset is left puts the device in debug mode.
// - Leave debug on control bit clear without read protect, or any device reset.
// - Pin low during stop mode requests a full system reset.
// - Characters are start, eight data bits LSB first, stop.
// - Bit period lies between clock/512 and clock/4.
// - Nine or more low bit times is a break; auto-baud resets.
// - Detect break, framing error and transmit collision.
// - On error abort, send 4096-cycle break, reset auto-baud.
// - Break keeps control and debug mode; link held until pin high.
// - Host break during device transmission is seen as an error.
// - Breakpoint opcode idles CPU when enabled, else acts as no-op.
// - Break loop keeps the CPU serving interrupts and DMA.
// - Status idle flag shows the CPU looping on a breakpoint.
// - Cleared loop bit makes the next breakpoint enter debug mode.
// - Most commands stay disabled while looping, outside debug mode.
// - 16-bit counter: cycle count, countdown break, or PC match.
// - Cycle mode clears on debug exit, stops on entry or saturation.
// - Counter doubles as transfer byte count and checksum residual.
// - Counter reads inverted, and FFFFH outside debug mode.
module spdc_ctrl
    import spdc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    // Debug pin, open drain
    input  wire logic        i_debug_pin,
    output logic             o_debug_pin_out,
    output logic             o_debug_pin_oe,
    // Link bytes to and from command logic
    output logic [7:0]       o_rx_data,
    output logic             o_rx_valid,
    input  wire logic [7:0]  i_tx_data,
    input  wire logic        i_tx_valid,
    output logic             o_tx_ready,
    output logic             o_abort,
    // Register access from command logic
    input  wire logic        i_ctl_wr,
    input  wire logic [7:0]  i_ctl_data,
    input  wire logic        i_read_protect,
    input  wire logic        i_cnt_wr,
    input  wire logic [15:0] i_cnt_data,
    input  wire logic        i_cnt_dec,
    output logic [15:0]      o_cnt_rd,
    output logic [7:0]       o_ctl_rd,
    output logic [7:0]       o_stat_rd,
    output logic             o_cmd_en,
    // CPU side
    input  wire logic        i_brk_decode,
    input  wire logic        i_pc_valid,
    input  wire logic [15:0] i_pc,
    input  wire logic        i_stop_mode,
    output logic             o_cpu_fetch_stop,
    output logic             o_halt_exit,
    output logic             o_wdt_refresh,
    output logic             o_brk_repeat,
    output logic             o_sys_reset_req
);
    typedef enum logic [3:0] {
        L_IDLE = 4'b0001,
        L_TX   = 4'b0010,
        L_BRK  = 4'b0100,
        L_HOLD = 4'b1000
    } spdc_link_st_t;

    typedef struct packed {
        logic          sync1;
        logic          sync2;
        spdc_link_st_t st;
        logic [9:0]    tx_sh;
        logic [9:0]    tick;
        logic [3:0]    bitn;
        logic [12:0]   brk_cnt;
        logic          oe;
        logic          tx_ready;
        logic          abort;
        logic          dbg;
        logic          brk_en;
        logic          break_loop_bit;
        logic          cnt_brk;
        logic          pc_sel;
        logic          looping;
        logic [15:0]   cnt;
        logic [1:0]    strap_wait;
        logic          rst_req;
        logic [15:0]   cnt_rd;
    } spdc_ctrl_t;

    spdc_ctrl_t q;
    spdc_ctrl_t d;
    logic       rx_cal;
    logic [9:0] rx_per;
    logic       rx_ferr;
    logic       rx_brk;
    logic       rx_busy;
    logic       link_hold;
    logic       link_mute;
    logic       coll;

    assign link_hold = q.st == L_BRK || q.st == L_HOLD;
    assign link_mute = q.st == L_TX;

    spdc_rx u_rx (
        .i_ref_clk   (i_ref_clk),
        .i_arst_n    (i_arst_n),
        .i_hold_rst  (link_hold),
        .i_mute      (link_mute),
        .i_pin       (q.sync2),
        .o_cal       (rx_cal),
        .o_period    (rx_per),
        .o_rx_data   (o_rx_data),
        .o_rx_valid  (o_rx_valid),
        .o_frame_err (rx_ferr),
        .o_break     (rx_brk),
        .o_busy      (rx_busy)
    );

    always_comb
    begin
        d = q;
        d.sync1 = i_debug_pin;
        d.sync2 = q.sync1;
        d.abort = 1'b0;
        coll = 1'b0;
        // Link: transmit, break out, wait for release
        case (q.st)
            L_IDLE:
            begin
                if (i_tx_valid && q.tx_ready && rx_cal && !rx_busy)
                begin
                    d.tx_sh = {1'b1, i_tx_data, 1'b0};
                    d.oe = 1'b1;
                    d.tick = rx_per;
                    d.bitn = 4'h0;
                    d.st = L_TX;
                end
            end
            L_TX:
            begin
                d.tick = q.tick - 10'h001;
                if (q.tick == {1'b0, rx_per[9:1]} && !q.oe && !q.sync2)
                    coll = 1'b1;
                if (q.tick == 10'h001)
                begin
                    d.tx_sh = {1'b1, q.tx_sh[9:1]};
                    d.bitn = q.bitn + 4'h1;
                    d.tick = rx_per;
                    d.oe = !q.tx_sh[1];
                    if (q.bitn == SPDC_LAST_BIT)
                    begin
                        d.oe = 1'b0;
                        d.st = L_IDLE;
                    end
                end
            end
            L_BRK:
            begin
                d.brk_cnt = q.brk_cnt - 13'h0001;
                if (q.brk_cnt == 13'h0001)
                begin
                    d.oe = 1'b0;
                    d.st = L_HOLD;
                end
            end
            L_HOLD:
            begin
                if (q.sync2)
                    d.st = L_IDLE;
            end
            default:
                d.st = L_IDLE;
        endcase
        // Any serial error aborts and answers with a break
        if ((rx_ferr || rx_brk || coll) && !link_hold)
        begin
            d.abort = 1'b1;
            d.oe = 1'b1;
            d.brk_cnt = SPDC_BREAK_CYC;
            d.st = L_BRK;
        end
        d.tx_ready = d.st == L_IDLE && rx_cal && !rx_busy &&
                     !(q.st == L_IDLE && i_tx_valid && q.tx_ready);

        // Control register writes
        if (i_ctl_wr)
        begin
            d.brk_en = i_ctl_data[SPDC_CTL_BRKEN];
            d.break_loop_bit = i_ctl_data[SPDC_CTL_BREAK_LOOP_BIT];
            d.cnt_brk = i_ctl_data[SPDC_CTL_CNTBRK];
            d.pc_sel = i_ctl_data[SPDC_CTL_PCSEL];
            if (i_ctl_data[SPDC_CTL_DBG])
                d.dbg = 1'b1;
            else if (!i_read_protect)
                d.dbg = 1'b0;
        end

        // Debug counter
        if (q.dbg)
        begin
            if (i_cnt_wr)
                d.cnt = i_cnt_data;
            else if (i_cnt_dec && q.cnt != SPDC_CNT_ZERO)
                d.cnt = q.cnt - SPDC_CNT_ONE;
        end
        else if (!q.cnt_brk || !q.pc_sel)
        begin
            if (q.cnt != SPDC_CNT_ZERO)
                d.cnt = q.cnt - SPDC_CNT_ONE;
            if (q.cnt_brk && q.cnt == SPDC_CNT_ONE)
                d.dbg = 1'b1;
        end
        else if (i_pc_valid && i_pc == q.cnt)
            d.dbg = 1'b1;

        // Breakpoint instruction
        if (i_brk_decode && q.brk_en && !q.dbg)
        begin
            if (q.break_loop_bit)
                d.looping = 1'b1;
            else
                d.dbg = 1'b1;
        end

        // Reset strap once the synchroniser holds the pin
        if (q.strap_wait != 2'h3)
        begin
            d.strap_wait = q.strap_wait + 2'h1;
            if (q.strap_wait == SPDC_STRAP_WAIT && !q.sync2)
                d.dbg = 1'b1;
        end

        if (d.dbg)
            d.looping = 1'b0;
        // Cycle count restarts from zero on exit
        if (q.dbg && !d.dbg && !d.cnt_brk)
            d.cnt = SPDC_CNT_MAX;
        if (i_stop_mode && !q.sync2)
            d.rst_req = 1'b1;
        d.cnt_rd = d.dbg ? ~d.cnt : SPDC_CNT_MAX;
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            q <= '0;
            q.sync1 <= 1'b1;
            q.sync2 <= 1'b1;
            q.st <= L_IDLE;
            q.cnt_rd <= SPDC_CNT_MAX;
            {q.dbg, q.brk_en, q.break_loop_bit, q.cnt_brk, q.pc_sel} <=
                SPDC_CTL_RST[7:3];
        end
        else
            q <= d;
    end

    // Outputs
    assign o_debug_pin_out = 1'b0;
    assign o_debug_pin_oe = q.oe;
    assign o_tx_ready = q.tx_ready;
    assign o_abort = q.abort;
    assign o_cnt_rd = q.cnt_rd;
    assign o_ctl_rd = {q.dbg, q.brk_en, q.break_loop_bit, q.cnt_brk, q.pc_sel,
                       3'h0};
    assign o_stat_rd = {q.dbg, q.looping, 6'h00};
    assign o_cmd_en = q.dbg && !q.looping;
    assign o_cpu_fetch_stop = q.dbg;
    assign o_halt_exit = q.dbg;
    assign o_wdt_refresh = q.dbg;
    assign o_brk_repeat = q.looping;
    assign o_sys_reset_req = q.rst_req;

endmodule

// ==== src/spdc_pkg.sv ====
/*
 * Shared constants for the single pin debug controller: control and
 * status bit positions, reset values, counter limits and link timing.
 * Assumes a 125 MHz system clock and an external pull-up on the pin.
 */
package spdc_pkg;

    // System clock
    localparam int unsigned SPDC_CLK_HZ       = 125_000_000;

    // Character format
    localparam logic [3:0]  SPDC_DATA_BITS    = 4'h8;
    localparam logic [3:0]  SPDC_LAST_BIT     = 4'h9;

    // Auto-baud limits: divider in clocks per bit, counter caps in clocks
    localparam logic [9:0]  SPDC_MIN_DIV      = 10'h004;
    localparam logic [9:0]  SPDC_MAX_DIV      = 10'h200;
    localparam logic [12:0] SPDC_MEAS_MAX     = 13'h1fff;
    localparam logic [13:0] SPDC_LOW_MAX      = 14'h3fff;
    // Nine bit times at the slowest rate
    localparam logic [13:0] SPDC_UNCAL_BRK    = 14'h1200;

    // Outgoing break length in system clocks
    localparam logic [12:0] SPDC_BREAK_CYC    = 13'h1000;

    // Control register bit positions
    localparam int unsigned SPDC_CTL_DBG      = 7;
    localparam int unsigned SPDC_CTL_BRKEN    = 6;
    localparam int unsigned SPDC_CTL_BREAK_LOOP_BIT    = 5;
    localparam int unsigned SPDC_CTL_CNTBRK   = 4;
    localparam int unsigned SPDC_CTL_PCSEL    = 3;
    localparam logic [7:0]  SPDC_CTL_RST      = 8'h00;

    // Status register bit positions
    localparam int unsigned SPDC_STAT_DBG     = 7;
    localparam int unsigned SPDC_STAT_IDLE    = 6;

    // Debug counter values
    localparam logic [15:0] SPDC_CNT_MAX      = 16'hffff;
    localparam logic [15:0] SPDC_CNT_ZERO     = 16'h0000;
    localparam logic [15:0] SPDC_CNT_ONE      = 16'h0001;

    // Cycles before the reset strap is sampled
    localparam logic [1:0]  SPDC_STRAP_WAIT   = 2'h2;

endpackage

// ==== src/spdc_rx.sv ====
/*
 * Receiver and auto-baud detector of the debug link: measures the
 * calibration character, receives characters, flags framing errors
 * and serial breaks. Assumes a synchronised pin level on i_pin.
 */
`timescale 1ns/100ps
module spdc_rx
    import spdc_pkg::*;
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_arst_n,
    // Control from the link owner
    input  wire logic       i_hold_rst,
    input  wire logic       i_mute,
    input  wire logic       i_pin,
    // Results
    output logic            o_cal,
    output logic [9:0]      o_period,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_valid,
    output logic            o_frame_err,
    output logic            o_break,
    output logic            o_busy
);
    typedef enum logic [4:0] {
        R_CAL  = 5'b00001,
        R_MEAS = 5'b00010,
        R_IDLE = 5'b00100,
        R_DATA = 5'b01000,
        R_STOP = 5'b10000
    } spdc_rx_st_t;

    typedef struct packed {
        spdc_rx_st_t st;
        logic        pin;
        logic [13:0] low;
        logic [12:0] meas;
        logic [9:0]  per;
        logic [9:0]  tick;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic [7:0]  data;
        logic        valid;
        logic        ferr;
        logic        breakpoint_instruction;
        logic        brk_seen;
        logic        cal;
    } spdc_rx_t;

    spdc_rx_t q;
    spdc_rx_t d;
    logic [13:0] nine_bits;

    always_comb
    begin
        d = q;
        d.valid = 1'b0;
        d.ferr = 1'b0;
        d.breakpoint_instruction = 1'b0;
        d.pin = i_pin;
        nine_bits = {1'b0, q.per, 3'b000} + {4'h0, q.per};
        // Low run length for break detection
        if (i_pin || i_mute)
            d.low = 14'h0000;
        else if (q.low != SPDC_LOW_MAX)
            d.low = q.low + 14'h0001;
        if (q.brk_seen && i_pin)
            d.brk_seen = 1'b0;
        case (q.st)
            R_CAL:
            begin
                if (!q.brk_seen && q.pin && !i_pin)
                begin
                    d.st = R_MEAS;
                    d.meas = 13'h0001;
                end
            end
            R_MEAS:
            begin
                if (i_pin)
                begin
                    d.per = q.meas[12:3];
                    if (q.meas[12:3] >= SPDC_MIN_DIV &&
                        q.meas[12:3] <= SPDC_MAX_DIV)
                    begin
                        d.cal = 1'b1;
                        d.st = R_IDLE;
                    end
                    else
                        d.st = R_CAL;
                end
                else if (q.meas != SPDC_MEAS_MAX)
                    d.meas = q.meas + 13'h0001;
            end
            R_IDLE:
            begin
                if (!i_mute && q.pin && !i_pin)
                begin
                    d.tick = q.per + {1'b0, q.per[9:1]};
                    d.bitn = 4'h0;
                    d.st = R_DATA;
                end
            end
            R_DATA:
            begin
                d.tick = q.tick - 10'h001;
                if (q.tick == 10'h001)
                begin
                    d.sh = {i_pin, q.sh[7:1]};
                    d.bitn = q.bitn + 4'h1;
                    d.tick = q.per;
                    if (q.bitn == SPDC_DATA_BITS - 4'h1)
                        d.st = R_STOP;
                end
            end
            R_STOP:
            begin
                d.tick = q.tick - 10'h001;
                if (q.tick == 10'h001)
                begin
                    d.st = R_IDLE;
                    if (i_pin)
                    begin
                        d.data = q.sh;
                        d.valid = 1'b1;
                    end
                    else
                        d.ferr = 1'b1;
                end
            end
            default:
                d.st = R_CAL;
        endcase
        // Break: nine bit times low, or too long to calibrate
        if (!i_pin && !q.brk_seen && !i_mute &&
            (q.cal ? (q.low >= nine_bits) : (q.low >= SPDC_UNCAL_BRK)))
        begin
            d.breakpoint_instruction = 1'b1;
            d.brk_seen = 1'b1;
            d.cal = 1'b0;
            d.st = R_CAL;
        end
        if (i_hold_rst)
        begin
            d.st = R_CAL;
            d.cal = 1'b0;
            d.brk_seen = 1'b0;
            d.low = 14'h0000;
            d.breakpoint_instruction = 1'b0;
            d.ferr = 1'b0;
            d.valid = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            q <= '0;
            q.st <= R_CAL;
            q.pin <= 1'b1;
        end
        else
            q <= d;
    end

    assign o_cal = q.cal;
    assign o_period = q.per;
    assign o_rx_data = q.data;
    assign o_rx_valid = q.valid;
    assign o_frame_err = q.ferr;
    assign o_break = q.breakpoint_instruction;
    assign o_busy = q.st == R_DATA || q.st == R_STOP;

endmodule

// ==== verif/spdc_chk.sv ====
/* Port checker for the single pin debug controller top.
   Assumes it is bound to spdc_ctrl and sees only its ports. */
`timescale 1ns/100ps
module spdc_chk (
    // Clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_arst_n,
    // Link
    input wire logic        i_debug_pin,
    input wire logic        o_debug_pin_out,
    input wire logic        o_debug_pin_oe,
    input wire logic        i_tx_valid,
    input wire logic        o_tx_ready,
    input wire logic        o_abort,
    // Registers
    input wire logic        i_ctl_wr,
    input wire logic [7:0]  i_ctl_data,
    input wire logic        i_read_protect,
    input wire logic [15:0] o_cnt_rd,
    input wire logic [7:0]  o_ctl_rd,
    input wire logic        o_cmd_en,
    // CPU side
    input wire logic        i_brk_decode,
    input wire logic        i_stop_mode,
    input wire logic        o_cpu_fetch_stop,
    input wire logic        o_halt_exit,
    input wire logic        o_wdt_refresh,
    input wire logic        o_brk_repeat,
    input wire logic        o_sys_reset_req
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    property p_dbg_outs;
        o_cpu_fetch_stop == o_halt_exit && o_halt_exit == o_wdt_refresh;
    endproperty
    a_dbg_outs: assert property (p_dbg_outs)
        else $error("debug mode outputs disagree");
    property p_pin_out; o_debug_pin_out == 1'b0; endproperty
    a_pin_out: assert property (p_pin_out)
        else $error("pin data not low");
    property p_ctl_enter; i_ctl_wr && i_ctl_data[7] |=> o_cpu_fetch_stop;
    endproperty
    a_ctl_enter: assert property (p_ctl_enter)
        else $error("no debug entry");
    property p_ctl_exit;
        i_ctl_wr && !i_ctl_data[7] && !i_ctl_data[4] && !o_ctl_rd[4]
        && !i_read_protect && !i_brk_decode |=> !o_cpu_fetch_stop;
    endproperty
    a_ctl_exit: assert property (p_ctl_exit)
        else $error("no debug exit");
    property p_cnt_idle;
        !o_cpu_fetch_stop && $past(!o_cpu_fetch_stop) |-> o_cnt_rd == 16'hffff;
    endproperty
    a_cnt_idle: assert property (p_cnt_idle)
        else $error("counter not ffff");
    property p_brk_enter;
        i_brk_decode && o_ctl_rd[6:5] == 2'h2 && !i_ctl_wr && $past(!i_ctl_wr)
        |=> o_cpu_fetch_stop;
    endproperty
    a_brk_enter: assert property (p_brk_enter)
        else $error("breakpoint missed");
    property p_brk_nop;
        i_brk_decode && !o_cpu_fetch_stop && !o_ctl_rd[6] && !o_ctl_rd[4]
        && !i_ctl_wr && $past(!i_ctl_wr) |=> !o_cpu_fetch_stop;
    endproperty
    a_brk_nop: assert property (p_brk_nop)
        else $error("breakpoint not nop");
    property p_tx_start;
        i_tx_valid && o_tx_ready |=> o_debug_pin_oe && !o_tx_ready;
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("no start bit");
    property p_err_break; o_abort |-> ##[0:2] o_debug_pin_oe [*8]; endproperty
    a_err_break: assert property (p_err_break)
        else $error("no break sent after error");
    property p_break_keeps;
        o_abort && o_cpu_fetch_stop && !i_ctl_wr |=> o_cpu_fetch_stop;
    endproperty
    a_break_keeps: assert property (p_break_keeps)
        else $error("serial error left debug mode");
    property p_loop; o_brk_repeat |-> !o_cmd_en && !o_cpu_fetch_stop;
    endproperty
    a_loop: assert property (p_loop)
        else $error("loop state bad");
    property p_stop_rst;
        (i_stop_mode && !i_debug_pin) [*4] |-> ##[0:3] o_sys_reset_req;
    endproperty
    a_stop_rst: assert property (p_stop_rst)
        else $error("no stop reset");
    property p_req_hold; o_sys_reset_req |=> o_sys_reset_req; endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("reset request dropped");
endmodule

bind spdc_ctrl spdc_chk u_spdc_chk (.*);

// ==== verif/spdc_host_model.sv ====
/* Host debugger model on the open drain debug pin.
   Assumes the bench resolves the wire with a pull-up. */
`timescale 1ns/100ps
module spdc_host_model #(
    parameter int PER = 16
) (
    input  wire logic i_ref_clk,
    input  wire logic i_pin,
    output logic      o_drive
);
    initial o_drive = 1'b0;

    // Ten bits LSB first, one bit per PER clocks
    task automatic put(input logic [9:0] f);
        int k;
        for (k = 0; k < 10; k++)
        begin
            @(posedge i_ref_clk);
            o_drive <= !f[k];
            repeat (PER - 1) @(posedge i_ref_clk);
        end
        @(posedge i_ref_clk);
        o_drive <= 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b);
        put({1'b1, b, 1'b0});
    endtask

    // Break, also usable over a device transmission
    task automatic hold_low(input int n);
        @(posedge i_ref_clk);
        o_drive <= 1'b1;
        repeat (n) @(posedge i_ref_clk);
        o_drive <= 1'b0;
    endtask

    task automatic get_byte(output logic [7:0] b);
        int i;
        int k;
        for (i = 0; i_pin && i < 4000; i++) @(posedge i_ref_clk);
        repeat (PER + PER / 2) @(posedge i_ref_clk);
        for (k = 0; k < 8; k++)
        begin
            b[k] = i_pin;
            repeat (PER) @(posedge i_ref_clk);
        end
    endtask
endmodule

// ==== verif/spdc_ctrl_bench.sv ====
/* Self-checking bench for spdc_ctrl with a host model on the pin.
   Assumes a 125 MHz clock and a pull-up on the debug pin. */
`timescale 1ns/100ps
module spdc_ctrl_bench;
    import spdc_pkg::*;
    localparam int PER = 16;
    logic        clk, arst_n, tx_valid, ctl_wr, rprot, cnt_wr, cnt_dec;
    logic        breakpoint_instruction, pc_valid, stop, tb_low, host_low, oe, pout, rx_valid;
    logic        tx_ready, abort, cmd_en, fstop, hexit, wdt, brep, sreq;
    logic [7:0]  tx_data, ctl_data, rx_data, ctl_rd, stat_rd, got, rx_got, b;
    logic [15:0] cnt_data, pc, cnt_rd, v;
    wire         pin;
    int          n_mismatch = 0, tests_run = 0, n_abort = 0, run = 0;
    int          oe_last = 0, n, seed;

    assign pin = !(oe || host_low || tb_low);

    spdc_host_model #(.PER(PER)) u_spdc_host_model (
        .i_ref_clk(clk), .i_pin(pin), .o_drive(host_low));

    spdc_ctrl u_spdc_ctrl (
        .i_ref_clk(clk), .i_arst_n(arst_n), .i_debug_pin(pin),
        .o_debug_pin_out(pout), .o_debug_pin_oe(oe), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
        .o_tx_ready(tx_ready), .o_abort(abort), .i_ctl_wr(ctl_wr),
        .i_ctl_data(ctl_data), .i_read_protect(rprot), .i_cnt_wr(cnt_wr),
        .i_cnt_data(cnt_data), .i_cnt_dec(cnt_dec), .o_cnt_rd(cnt_rd),
        .o_ctl_rd(ctl_rd), .o_stat_rd(stat_rd), .o_cmd_en(cmd_en),
        .i_brk_decode(breakpoint_instruction), .i_pc_valid(pc_valid), .i_pc(pc),
        .i_stop_mode(stop), .o_cpu_fetch_stop(fstop), .o_halt_exit(hexit),
        .o_wdt_refresh(wdt), .o_brk_repeat(brep), .o_sys_reset_req(sreq));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Byte, abort and drive tallies
    always @(posedge clk)
    begin
        if (rx_valid) rx_got <= rx_data;
        if (abort) n_abort <= n_abort + 1;
        if (oe) run <= run + 1;
        else if (run != 0)
        begin
            oe_last <= run;
            run <= 0;
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic ctl(input logic [7:0] d);
        @(posedge clk);
        ctl_wr <= 1'b1;
        ctl_data <= d;
        @(posedge clk);
        ctl_wr <= 1'b0;
        tick(2);
    endtask

    task automatic cnt_load(input logic [15:0] d);
        @(posedge clk);
        cnt_wr <= 1'b1;
        cnt_data <= d;
        @(posedge clk);
        cnt_wr <= 1'b0;
        tick(2);
    endtask

    task automatic pulse_brk;
        @(posedge clk);
        breakpoint_instruction <= 1'b1;
        @(posedge clk);
        breakpoint_instruction <= 1'b0;
        tick(3);
    endtask

    task automatic wait_quiet;
        for (n = 0; (oe || !pin) && n < 20000; n++) @(posedge clk);
        tick(20);
    endtask

    task automatic recal;
        wait_quiet();
        u_spdc_host_model.send_byte(8'h80);
        for (n = 0; !tx_ready && n < 200; n++) @(negedge clk);
        chk(tx_ready, 1'b1);
    endtask

    task automatic send_tx(input logic [7:0] d);
        @(posedge clk);
        tx_data <= d;
        tx_valid <= 1'b1;
        @(negedge clk);
        while (!tx_ready) @(negedge clk);
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask

    initial
    begin
        {arst_n, tx_valid, ctl_wr, rprot, cnt_wr, cnt_dec} = '0;
        {breakpoint_instruction, pc_valid, stop, tb_low, tx_data, ctl_data, cnt_data, pc} = '0;
        seed = $urandom(6902);
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        tick(8);
        chk(fstop, 1'b0);
        chk(cnt_rd, SPDC_CNT_MAX);
        chk(ctl_rd, SPDC_CTL_RST);
        u_spdc_host_model.hold_low(5000);
        wait_quiet();
        chk(16'(oe_last), 16'h1000);
        chk(16'(n_abort), 16'h0001);
        recal();
        for (int i = 0; i < 6; i++)
        begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            u_spdc_host_model.send_byte(b);
            tick(2);
            chk(rx_got, b);
        end
        for (int i = 0; i < 3; i++)
        begin
            b = 8'($urandom);
            fork
                u_spdc_host_model.get_byte(got);
                send_tx(b);
            join
            chk(got, b);
            tick(2 * PER);
        end
        u_spdc_host_model.put({1'b0, 8'h55, 1'b0});
        wait_quiet();
        chk(16'(n_abort), 16'h0002);
        recal();
        ctl(8'h80);
        chk(fstop, 1'b1);
        chk({wdt, hexit, stat_rd[7]}, 3'h7);
        cnt_load(16'h0005);
        chk(cnt_rd, ~16'h0005);
        @(posedge clk);
        cnt_dec <= 1'b1;
        @(posedge clk);
        cnt_dec <= 1'b0;
        tick(2);
        chk(cnt_rd, ~16'h0004);
        @(posedge clk);
        rprot <= 1'b1;
        ctl(8'h00);
        chk(fstop, 1'b1);
        @(posedge clk);
        rprot <= 1'b0;
        ctl(8'h00);
        chk(fstop, 1'b0);
        chk(cnt_rd, SPDC_CNT_MAX);
        tick(96);
        ctl(8'h80);
        v = cnt_rd;
        chk(v >= 16'd95 && v <= 16'd108, 1'b1);
        tick(20);
        chk(cnt_rd, v);
        ctl(8'h00);
        pulse_brk();
        chk(fstop, 1'b0);
        ctl(8'h60);
        pulse_brk();
        chk({brep, stat_rd[6], cmd_en, fstop}, 4'hc);
        ctl(8'h40);
        pulse_brk();
        chk({fstop, stat_rd[6], cmd_en, ctl_rd[7]}, 4'hb);
        cnt_load(16'h0020);
        ctl(8'h50);
        for (n = 0; !fstop && n < 100; n++) @(negedge clk);
        chk(n >= 24 && n <= 36, 1'b1);
        cnt_load(16'h0abc);
        ctl(8'h58);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            pc_valid <= 1'b1;
            pc <= 16'($urandom) | 16'h1000;
        end
        tick(2);
        chk(fstop, 1'b0);
        @(posedge clk);
        pc <= 16'h0abc;
        tick(4);
        chk(fstop, 1'b1);
        pc_valid <= 1'b0;
        fork
            send_tx(8'hff);
            begin
                tick(3 * PER);
                u_spdc_host_model.hold_low(3000);
            end
        join
        wait_quiet();
        chk(16'(n_abort), 16'h0003);
        chk({fstop, ctl_rd[7]}, 2'h3);
        @(posedge clk);
        stop <= 1'b1;
        tb_low <= 1'b1;
        tick(8);
        chk(sreq, 1'b1);
        @(posedge clk);
        arst_n <= 1'b0;
        stop <= 1'b0;
        tick(2);
        chk({fstop, sreq}, 2'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        tick(8);
        chk(fstop, 1'b1);
        tb_low <= 1'b0;
        tick(4);
        tally_and_finish();
    end

    initial
    begin
        #600000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
